// ### design/serial_nvm_program_command_engine.sv
// Target-side serial programming command engine for nonvolatile memory
// Contract
// - Load-data stores one latch: 16-bit word, or 8-bit for data EEPROM.
// - Memory changes only on a later begin-programming command, never on load.
// - Command bit 1 on load/read data advances the address after transfer.
// - Read payload drives the data pin from first to 24th falling edge.
// - Increment adds 2 in program flash, 1 in data EEPROM; never decrements.
// - Load-address sets the counter and selects the memory panel.
// - Begin-internal starts self-timed programming; host waits before next command.
// - Completed programming cycle sets all data latches to ones.
// - Begin-internal is ignored while the code-protect bit is zero.
// - Externally timed write to configuration or calibration words has no effect.
// - End-external ends an external cycle, else acts as no-operation.
// - Unprotected bulk erase picks regions from the address range.
// - Protected bulk erase of flash or user-ID ranges also erases EEPROM.
// - Bulk erase is device-timed; host waits the full erase time.
// - Row erase clears the addressed row, ignored when code-protected.
// - Flash row is 32 words in 64 byte latches; others per word/byte.
// - Low address bits pick latches; row taken at begin, writes wrap.
// - Extra loads overwrite the latch at the same low-order position.
// - Protected reads of flash and EEPROM return zero; programming refused.
// - ID, information, user-ID and configuration areas always read true.
// - Command byte encodings as fixed by the command set.
// - Payload is 24 clocks: start, pads, data MSB first, stop.
// - Bits travel MSB first; both sides sample on the falling clock edge.
// - Entering programming mode clears the address counter first.
`timescale 1ns/1ps
module serial_nvm_program_command_engine
	import nvm_prog_pkg::*;
#(
	parameter int LATCHES = ROW_LATCHES,
	parameter int unsigned INT_FLASH_CYCLES = INTERNAL_WRITE_TIME_FLASH_US * CLK_MHZ,
	parameter int unsigned INT_OTHER_CYCLES = INTERNAL_WRITE_TIME_OTHER_US * CLK_MHZ,
	parameter int unsigned BULK_ERASE_CYCLES = BULK_ERASE_TIME_US * CLK_MHZ,
	parameter int unsigned ROW_ERASE_CYCLES = ROW_ERASE_TIME_US * CLK_MHZ
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic prog_mode,
	input wire logic code_protect_n,
	input wire logic prog_clock_pin,
	input wire logic prog_data_pin_in,
	output logic prog_data_pin_out,
	output logic prog_data_pin_oe,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_rd_req,
	input wire logic mem_rd_valid,
	output logic mem_rd_ready,
	input wire logic [DATA_W-1:0] mem_rd_data,
	output logic mem_start,
	output logic [4:0] mem_op,
	output logic [3:0] mem_erase_sel,
	output logic mem_done,
	output logic busy,
	output logic [8*LATCHES-1:0] mem_row_data
);
	localparam int LATCH_AW = $clog2(LATCHES);
	localparam int BIT_CNT_W = 5;

	generate
		if (LATCHES != ROW_LATCHES || LATCHES != 2 * ROW_WORDS)
		begin : g_bad_latches
			$error("latch count must match a row of byte latches");
		end
		if (INT_FLASH_CYCLES < 1 || INT_OTHER_CYCLES < 1 || ROW_ERASE_CYCLES < 1
			|| BULK_ERASE_CYCLES < 1)
		begin : g_bad_short
			$error("operation times must be at least one cycle");
		end
		if (INT_OTHER_CYCLES >= 2 ** TIMER_W || BULK_ERASE_CYCLES >= 2 ** TIMER_W
			|| INT_FLASH_CYCLES >= 2 ** TIMER_W || ROW_ERASE_CYCLES >= 2 ** TIMER_W)
		begin : g_bad_long
			$error("operation time exceeds the timer width");
		end
	endgenerate

	// Link sampling
	logic [1:0] pins_sync;
	logic clk_prev;

	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.async_in({prog_clock_pin, prog_data_pin_in}),
		.sync_out(pins_sync)
	);

	wire clk_s = pins_sync[1];
	wire dat_s = pins_sync[0];
	wire link_fall = clk_prev && !clk_s && prog_mode;
	wire link_rise = !clk_prev && clk_s && prog_mode;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			clk_prev <= 1'b0;
		else
			clk_prev <= clk_s;
	end

	// Bit framing
	link_state_t link_state;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [CMD_BITS-1:0] cmd_shift;
	logic [CMD_BITS-1:0] cmd_reg;
	logic [PAYLOAD_BITS-1:0] pay_shift;

	wire [CMD_BITS-1:0] cmd_full = {cmd_shift[CMD_BITS-2:0], dat_s};
	wire [PAYLOAD_BITS-1:0] pay_full = {pay_shift[PAYLOAD_BITS-2:0], dat_s};
	wire cmd_last = (bit_cnt == BIT_CNT_W'(CMD_BITS - 1));
	wire pay_last = (bit_cnt == BIT_CNT_W'(PAYLOAD_BITS - 1));
	wire cmd_done = link_fall && (link_state == LINK_CMD) && cmd_last;
	wire pay_done = link_fall && (link_state == LINK_PAY_IN) && pay_last;
	wire out_first = link_fall && (link_state == LINK_PAY_OUT) && (bit_cnt == '0);
	wire out_last = link_fall && (link_state == LINK_PAY_OUT) && pay_last;

	// Payload classes; anything else takes no payload
	wire is_load_cmd = (cmd_full == CMD_LOAD_DATA) || (cmd_full == CMD_LOAD_DATA_INC);
	wire is_read_cmd = (cmd_full == CMD_READ_DATA) || (cmd_full == CMD_READ_DATA_INC);
	wire wants_in = is_load_cmd || (cmd_full == CMD_LOAD_ADDR);
	wire reg_is_load = (cmd_reg == CMD_LOAD_DATA) || (cmd_reg == CMD_LOAD_DATA_INC);

	always_ff @(posedge core_clk)
	begin
		if (!rstn || !prog_mode)
		begin
			link_state <= LINK_CMD;
			bit_cnt <= '0;
			cmd_shift <= '0;
			cmd_reg <= '0;
			pay_shift <= '0;
		end
		else if (link_fall)
		begin
			bit_cnt <= bit_cnt + 1'b1;
			case (link_state)
				LINK_CMD:
				begin
					cmd_shift <= cmd_full;
					if (cmd_last)
					begin
						bit_cnt <= '0;
						cmd_reg <= cmd_full;
						if (is_read_cmd)
							link_state <= LINK_PAY_OUT;
						else if (wants_in)
							link_state <= LINK_PAY_IN;
						else
							link_state <= LINK_CMD;
					end
				end
				LINK_PAY_IN:
				begin
					pay_shift <= pay_full;
					if (pay_last)
					begin
						bit_cnt <= '0;
						link_state <= LINK_CMD;
					end
				end
				LINK_PAY_OUT:
				begin
					if (pay_last)
					begin
						bit_cnt <= '0;
						link_state <= LINK_CMD;
					end
				end
				default:
				begin
					bit_cnt <= '0;
					link_state <= LINK_CMD;
				end
			endcase
		end
	end

	// Address counter and region decode
	logic [ADDR_W-1:0] addr;

	wire in_flash = (addr <= FLASH_LAST);
	wire in_eeprom = (addr >= EEPROM_FIRST) && (addr <= EEPROM_LAST);
	wire in_userid = (addr >= USERID_FIRST) && (addr <= USERID_LAST);
	wire in_config = (addr >= CONFIG_FIRST) && !in_eeprom && !in_userid;
	wire [ADDR_W-1:0] addr_step = in_eeprom ? EEPROM_STEP : FLASH_STEP;
	wire [DATA_W-1:0] pay_data = pay_full[PAY_DATA_LSB +: DATA_W];
	wire step_after_load = pay_done && reg_is_load && cmd_reg[CMD_INC_BIT];
	wire step_after_read = out_last && cmd_reg[CMD_INC_BIT];
	wire step_cmd = cmd_done && (cmd_full == CMD_INC_ADDR);

	always_ff @(posedge core_clk)
	begin
		if (!rstn || !prog_mode)
			addr <= '0;
		else if (pay_done && cmd_reg == CMD_LOAD_ADDR)
			addr <= pay_full[PAY_DATA_LSB +: ADDR_W];
		else if (step_cmd || step_after_load || step_after_read)
			addr <= addr + addr_step;
	end

	// Memory operation control
	mem_state_t mem_state;
	logic [TIMER_W-1:0] timer;
	logic write_pending;

	wire mem_idle = (mem_state == MEM_IDLE);
	wire is_begin_int = cmd_done && (cmd_full == CMD_BEGIN_INT);
	wire is_begin_ext = cmd_done && (cmd_full == CMD_BEGIN_EXT);
	wire start_int = is_begin_int && mem_idle && code_protect_n;
	wire start_ext = is_begin_ext && mem_idle && code_protect_n && !in_config;
	wire start_row = cmd_done && (cmd_full == CMD_ROW_ERASE) && mem_idle
		&& code_protect_n && in_flash;
	wire end_ext = cmd_done && (cmd_full == CMD_END_EXT)
		&& (mem_state == MEM_EXTERNAL);
	wire timer_done = (mem_state == MEM_TIMED) && (timer == TIMER_W'(1));
	wire cycle_end = timer_done || end_ext;

	// Bulk erase regions by address, widened when protected
	wire bulk_low = in_flash;
	wire bulk_ids = in_userid;
	wire bulk_eep = in_eeprom || (!code_protect_n && (bulk_low || bulk_ids));
	wire [3:0] bulk_sel = {bulk_eep, bulk_ids, bulk_low || bulk_ids,
		bulk_low || bulk_ids};
	wire start_bulk = cmd_done && (cmd_full == CMD_BULK_ERASE) && mem_idle
		&& (bulk_sel != 4'h0);

	wire mem_op_t write_kind = in_flash ? OP_WRITE_ROW :
		(in_eeprom ? OP_WRITE_BYTE : OP_WRITE_WORD);
	wire [TIMER_W-1:0] int_time = in_flash ? TIMER_W'(INT_FLASH_CYCLES) :
		TIMER_W'(INT_OTHER_CYCLES);
	wire start_read = cmd_done && is_read_cmd && mem_idle;

	always_ff @(posedge core_clk)
	begin
		if (!rstn || !prog_mode)
		begin
			mem_state <= MEM_IDLE;
			timer <= '0;
			write_pending <= 1'b0;
			mem_start <= 1'b0;
			mem_op <= OP_NONE;
			mem_erase_sel <= 4'h0;
			mem_done <= 1'b0;
			mem_addr <= '0;
			mem_rd_req <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			mem_start <= 1'b0;
			mem_done <= 1'b0;
			mem_rd_req <= start_read;
			if (start_read)
				mem_addr <= addr;
			case (mem_state)
				MEM_IDLE:
				begin
					if (start_int || start_ext)
					begin
						mem_addr <= addr;
						mem_op <= write_kind;
						mem_erase_sel <= 4'h0;
						mem_start <= 1'b1;
						write_pending <= 1'b1;
						timer <= int_time;
						mem_state <= start_int ? MEM_TIMED : MEM_EXTERNAL;
						busy <= 1'b1;
					end
					else if (start_row || start_bulk)
					begin
						mem_addr <= addr;
						mem_op <= start_row ? OP_ERASE_ROW : OP_ERASE_BULK;
						mem_erase_sel <= start_row ? 4'h0 : bulk_sel;
						mem_start <= 1'b1;
						write_pending <= 1'b0;
						timer <= start_row ? TIMER_W'(ROW_ERASE_CYCLES) :
							TIMER_W'(BULK_ERASE_CYCLES);
						mem_state <= MEM_TIMED;
						busy <= 1'b1;
					end
				end
				MEM_TIMED:
				begin
					timer <= timer - 1'b1;
					if (timer_done)
					begin
						mem_done <= 1'b1;
						busy <= 1'b0;
						mem_state <= MEM_IDLE;
					end
				end
				MEM_EXTERNAL:
				begin
					if (end_ext)
					begin
						mem_done <= 1'b1;
						busy <= 1'b0;
						mem_state <= MEM_IDLE;
					end
				end
				default:
				begin
					busy <= 1'b0;
					mem_state <= MEM_IDLE;
				end
			endcase
		end
	end

	// Row data latches
	wire clear_latches = cycle_end && write_pending;
	wire load_strobe = pay_done && reg_is_load;
	logic [7:0] latch [LATCHES];

	genvar gi;
	generate
		for (gi = 0; gi < LATCHES; gi++)
		begin : g_latch
			localparam logic [LATCH_AW-1:0] IDX = LATCH_AW'(gi);
			wire byte_hit = in_eeprom ? (addr[LATCH_AW-1:0] == IDX) :
				(addr[LATCH_AW-1:1] == IDX[LATCH_AW-1:1]);
			wire [7:0] byte_val = (in_eeprom || !IDX[0]) ? pay_data[7:0] : pay_data[15:8];

			always_ff @(posedge core_clk)
			begin
				if (!rstn || !prog_mode || clear_latches)
					latch[gi] <= LATCH_RESET;
				else if (load_strobe && byte_hit)
					latch[gi] <= byte_val;
			end

			assign mem_row_data[8*gi +: 8] = latch[gi];
		end
	endgenerate

	// Read-back path through the two-entry buffer
	logic buf_valid;
	logic [DATA_W-1:0] buf_data;
	logic [PAYLOAD_BITS-1:0] out_shift;

	word_buffer #(
		.WIDTH(DATA_W),
		.DEPTH(2)
	) u_rd_buf (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(mem_rd_valid),
		.in_ready(mem_rd_ready),
		.in_data(mem_rd_data),
		.out_valid(buf_valid),
		.out_ready(out_first),
		.out_data(buf_data)
	);

	// Protected panels read as zero; ID and configuration areas read true
	wire hide_data = !code_protect_n && (in_flash || in_eeprom);
	wire [DATA_W-1:0] rd_width = in_eeprom ? {8'h00, buf_data[7:0]} : buf_data;
	wire [DATA_W-1:0] rd_value = (buf_valid && !hide_data) ? rd_width : '0;
	wire [PAYLOAD_BITS-1:0] out_word = {1'b0, {PAD_BITS{1'b0}}, rd_value, 1'b0};

	// The first bit goes out on the first falling edge, later bits on rising edges so the host samples them on falling ones
	always_ff @(posedge core_clk)
	begin
		if (!rstn || !prog_mode)
		begin
			prog_data_pin_oe <= 1'b0;
			prog_data_pin_out <= 1'b0;
			out_shift <= '0;
		end
		else if (out_first)
		begin
			prog_data_pin_oe <= 1'b1;
			prog_data_pin_out <= out_word[PAYLOAD_BITS-1];
			out_shift <= {out_word[PAYLOAD_BITS-2:0], 1'b0};
		end
		else if (out_last)
		begin
			prog_data_pin_oe <= 1'b0;
			prog_data_pin_out <= 1'b0;
		end
		else if (link_rise && prog_data_pin_oe)
		begin
			prog_data_pin_out <= out_shift[PAYLOAD_BITS-1];
			out_shift <= {out_shift[PAYLOAD_BITS-2:0], 1'b0};
		end
	end
endmodule

// ### include/nvm_prog_pkg.sv
// Shared constants and types for the serial nonvolatile-memory command engine
package nvm_prog_pkg;

	localparam int CLK_MHZ = 50;

	// Command encodings
	localparam logic [7:0] CMD_LOAD_ADDR = 8'h80;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h18;
	localparam logic [7:0] CMD_ROW_ERASE = 8'hF0;
	localparam logic [7:0] CMD_LOAD_DATA = 8'h00;
	localparam logic [7:0] CMD_LOAD_DATA_INC = 8'h02;
	localparam logic [7:0] CMD_READ_DATA = 8'hFC;
	localparam logic [7:0] CMD_READ_DATA_INC = 8'hFE;
	localparam logic [7:0] CMD_INC_ADDR = 8'hF8;
	localparam logic [7:0] CMD_BEGIN_INT = 8'hE0;
	localparam logic [7:0] CMD_BEGIN_EXT = 8'hC0;
	localparam logic [7:0] CMD_END_EXT = 8'h82;
	localparam int CMD_INC_BIT = 1;

	// Link framing
	localparam int CMD_BITS = 8;
	localparam int PAYLOAD_BITS = 24;
	localparam int PAY_DATA_LSB = 1;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int PAD_BITS = PAYLOAD_BITS - DATA_W - 2;

	// Address map
	localparam logic [ADDR_W-1:0] FLASH_LAST = 22'h01FFFF;
	localparam logic [ADDR_W-1:0] USERID_FIRST = 22'h300000;
	localparam logic [ADDR_W-1:0] USERID_LAST = 22'h30001F;
	localparam logic [ADDR_W-1:0] EEPROM_FIRST = 22'h310000;
	localparam logic [ADDR_W-1:0] EEPROM_LAST = 22'h3EFFFF;
	localparam logic [ADDR_W-1:0] CONFIG_FIRST = 22'h300000;
	localparam logic [ADDR_W-1:0] FLASH_STEP = 22'h000002;
	localparam logic [ADDR_W-1:0] EEPROM_STEP = 22'h000001;

	// Row latches
	localparam int ROW_WORDS = 32;
	localparam int ROW_LATCHES = 64;
	localparam logic [7:0] LATCH_RESET = 8'hFF;

	// Device-timed operation lengths in microseconds
	localparam int INTERNAL_WRITE_TIME_FLASH_US = 2800;
	localparam int INTERNAL_WRITE_TIME_OTHER_US = 5600;
	localparam int BULK_ERASE_TIME_US = 25200;
	localparam int ROW_ERASE_TIME_US = 2800;
	localparam int TIMER_W = 21;

	// Bulk erase region select bit positions
	localparam int ERASE_FLASH_BIT = 0;
	localparam int ERASE_CONFIG_BIT = 1;
	localparam int ERASE_USERID_BIT = 2;
	localparam int ERASE_EEPROM_BIT = 3;

	typedef enum logic [4:0]
	{
		OP_NONE = 5'h00,
		OP_WRITE_ROW = 5'h01,
		OP_WRITE_WORD = 5'h02,
		OP_WRITE_BYTE = 5'h04,
		OP_ERASE_ROW = 5'h08,
		OP_ERASE_BULK = 5'h10
	} mem_op_t;

	typedef enum logic [2:0]
	{
		LINK_CMD = 3'h1,
		LINK_PAY_IN = 3'h2,
		LINK_PAY_OUT = 3'h4
	} link_state_t;

	typedef enum logic [2:0]
	{
		MEM_IDLE = 3'h1,
		MEM_TIMED = 3'h2,
		MEM_EXTERNAL = 3'h4
	} mem_state_t;

endpackage

// ### design/pin_sync.sv
// Two-flop synchroniser for inputs arriving from outside the core clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// ### design/word_buffer.sv
// Small valid/ready buffer; ready on the fill side is registered
`timescale 1ns/1ps
module word_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("word_buffer depth must be a power of two of at least two");
		end
	endgenerate

	logic [WIDTH-1:0] slot [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [CNT_W-1:0] next_count = count + CNT_W'(push) - CNT_W'(pop);

	assign out_valid = (count != '0);
	assign out_data = slot[rd_ptr];

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
		end
		else
		begin
			if (push)
			begin
				slot[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready <= (next_count != FULL);
		end
	end
endmodule

// ### dv/nvm_engine_chk.sv
// Port-level assertions for the serial nvm command engine
`timescale 1ns/1ps
module nvm_engine_chk
	import nvm_prog_pkg::*;
#(
	parameter int LATCHES = 64,
	parameter int unsigned INT_FLASH_CYCLES = 1,
	parameter int unsigned INT_OTHER_CYCLES = 1,
	parameter int unsigned BULK_ERASE_CYCLES = 1,
	parameter int unsigned ROW_ERASE_CYCLES = 1
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic prog_mode,
	input wire logic code_protect_n,
	input wire logic prog_data_pin_oe,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_start,
	input wire logic [4:0] mem_op,
	input wire logic [3:0] mem_erase_sel,
	input wire logic mem_done,
	input wire logic busy,
	input wire logic [8*LATCHES-1:0] mem_row_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	int unsigned busy_cnt;
	int unsigned op_len;
	// Erase lengths only; write lengths depend on who ends the cycle
	assign op_len = (mem_op == OP_ERASE_BULK) ? BULK_ERASE_CYCLES : ROW_ERASE_CYCLES;
	always_ff @(posedge core_clk)
	begin
		if (!rstn || mem_start)
			busy_cnt <= 0;
		else if (busy)
			busy_cnt <= busy_cnt + 1;
	end
	sequence s_row_start;
		mem_start && mem_op == OP_ERASE_ROW;
	endsequence
	sequence s_row_hold;
		busy [*8];
	endsequence
	a_start_sets_busy: assert property (mem_start |=> busy)
		else $error("busy not raised after start");
	a_no_overlap_start: assert property (mem_start |-> !$past(busy))
		else $error("operation started while busy");
	a_done_drops_busy: assert property (mem_done |=> !busy)
		else $error("busy still high after done");
	a_done_clears_latches: assert property (mem_done && mem_op < OP_ERASE_ROW
		|=> &mem_row_data)
		else $error("latches not all ones after write");
	a_protect_blocks_write: assert property (mem_start && !code_protect_n
		|-> mem_op == OP_ERASE_BULK)
		else $error("write or row erase started while protected");
	a_protect_adds_eeprom: assert property (mem_start && mem_op == OP_ERASE_BULK
		&& !code_protect_n && mem_erase_sel[ERASE_FLASH_BIT] |-> mem_erase_sel[ERASE_EEPROM_BIT])
		else $error("protected bulk erase misses eeprom");
	a_eeprom_bulk_only: assert property (mem_start && mem_op == OP_ERASE_BULK
		&& mem_addr >= EEPROM_FIRST && mem_addr <= EEPROM_LAST |-> mem_erase_sel == 4'h8)
		else $error("eeprom range bulk erase selects other regions");
	a_mode_clears_addr: assert property (!prog_mode |=> mem_addr == '0 && !prog_data_pin_oe)
		else $error("address or pin not cleared outside programming mode");
	a_row_erase_hold: assert property (s_row_start |=> s_row_hold)
		else $error("row erase ended too early");
	a_erase_length: assert property (mem_done && mem_op >= OP_ERASE_ROW
		|-> busy_cnt + 2 >= op_len && busy_cnt <= op_len + 1)
		else $error("erase length wrong");
endmodule
bind serial_nvm_program_command_engine nvm_engine_chk #(.LATCHES(LATCHES),
	.INT_FLASH_CYCLES(INT_FLASH_CYCLES), .INT_OTHER_CYCLES(INT_OTHER_CYCLES),
	.BULK_ERASE_CYCLES(BULK_ERASE_CYCLES), .ROW_ERASE_CYCLES(ROW_ERASE_CYCLES)) chk (
	.core_clk(core_clk), .rstn(rstn), .prog_mode(prog_mode), .code_protect_n(code_protect_n),
	.prog_data_pin_oe(prog_data_pin_oe), .mem_addr(mem_addr), .mem_start(mem_start),
	.mem_op(mem_op), .mem_erase_sel(mem_erase_sel), .mem_done(mem_done), .busy(busy),
	.mem_row_data(mem_row_data));

// ### dv/nvm_host.sv
// Programming host model: makes the link clock and owns the data wire
`timescale 1ns/1ps
module nvm_host (
	output logic prog_clock_pin,
	output logic prog_data_pin_in,
	input wire logic prog_data_pin_out,
	input wire logic prog_data_pin_oe
);
	int half;
	int oe_falls;
	logic drive;
	logic host_bit;
	// A released wire has no keeper, so it shows the inverse of host_bit, never the old bit
	assign prog_data_pin_in = prog_data_pin_oe ? prog_data_pin_out : (drive ? host_bit : ~host_bit);
	initial
	begin
		half = 80;
		drive = 1'b1;
		host_bit = 1'b0;
		prog_clock_pin = 1'b0;
	end
	task automatic shift(input logic [23:0] tx, input int n, input logic rd, output logic [23:0] rx);
		rx = '0;
		#3;
		for (int i = n - 1; i >= 0; i--)
		begin
			prog_clock_pin = 1'b1;
			#5;
			drive = !rd;
			host_bit = tx[i];
			#(half - 5);
			prog_clock_pin = 1'b0;
			rx[i] = prog_data_pin_in;
			if (prog_data_pin_oe === 1'b1)
				oe_falls++;
			#half;
		end
		drive = 1'b1;
		host_bit = 1'b0;
		#1000;
	endtask
	// Clock stands low between frames; start, pad and stop of reads are left to the caller
	task automatic frame(input logic [7:0] cmd, input logic pay, input logic [23:0] tx,
		output logic [23:0] rx);
		logic [23:0] unused;
		oe_falls = 0;
		shift({16'h0, cmd}, 8, 1'b0, unused);
		rx = '0;
		if (pay)
			shift(tx, 24, cmd[7:2] == 6'h3F, rx);
	endtask
endmodule

// ### dv/serial_nvm_program_command_engine_test.sv
// Self-checking bench for the serial nvm command engine
`timescale 1ns/1ps
module serial_nvm_program_command_engine_test;
	import nvm_prog_pkg::*;
	typedef struct packed {
		logic [21:0] addr;
		logic [7:0] cmd;
		logic cp;
		logic [15:0] w;
		logic [15:0] e;
		logic [21:0] ea;
	} row_t;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic prog_mode = 1'b0;
	logic code_protect_n = 1'b1;
	logic prog_clock_pin, prog_data_pin_in, prog_data_pin_out, prog_data_pin_oe;
	logic [ADDR_W-1:0] mem_addr, rd_addr;
	logic mem_rd_req, mem_rd_ready, mem_start, mem_done, busy, started, taken;
	logic mem_rd_valid = 1'b0;
	logic [15:0] mem_w = 16'h0;
	logic [DATA_W-1:0] mem_rd_data;
	logic [4:0] mem_op, cap_op;
	logic [3:0] mem_erase_sel, cap_sel;
	logic [511:0] mem_row_data;
	logic [23:0] rx;
	row_t r;
	int num_errors = 0;
	int checks = 0;
	row_t rows [19] = '{
		'{22'h10, 8'hFC, 1, 16'hA5C3, 16'hA5C3, 22'h10}, '{22'h10, 8'hFE, 1, 16'h1234, 16'h1234, 22'h12},
		'{22'h310005, 8'hFE, 1, 16'hAB, 16'hAB, 22'h310006}, '{22'h100, 8'hF8, 1, 0, 0, 22'h102},
		'{22'h20, 8'hFC, 0, 16'hBEEF, 0, 22'h20}, '{22'h310000, 8'hFC, 0, 16'h55, 0, 22'h310000},
		'{22'h300000, 8'hFC, 0, 16'h1357, 16'h1357, 22'h300000}, '{22'h0, 8'hE0, 1, 0, 16'h1, 22'h0},
		'{22'h310000, 8'hE0, 1, 0, 16'h4, 22'h310000}, '{22'h300000, 8'hE0, 1, 0, 16'h2, 22'h300000},
		'{22'h0, 8'hE0, 0, 0, 0, 22'h0}, '{22'h40, 8'hF0, 1, 0, 16'h8, 22'h40},
		'{22'h40, 8'hF0, 0, 0, 0, 22'h40}, '{22'h3F0000, 8'hC0, 1, 0, 0, 22'h3F0000},
		'{22'h0, 8'hC0, 1, 0, 16'h1, 22'h0}, '{22'h0, 8'h18, 1, 0, 16'h70, 22'h0},
		'{22'h310000, 8'h18, 1, 0, 16'h110, 22'h310000}, '{22'h300000, 8'h18, 0, 0, 16'h1F0, 22'h300000},
		'{22'h0, 8'h55, 1, 0, 0, 22'h0}};
	always #10 core_clk = ~core_clk;
	serial_nvm_program_command_engine #(.INT_FLASH_CYCLES(40), .INT_OTHER_CYCLES(60),
		.BULK_ERASE_CYCLES(80), .ROW_ERASE_CYCLES(50)) uut (.core_clk(core_clk), .rstn(rstn),
		.prog_mode(prog_mode), .code_protect_n(code_protect_n), .prog_clock_pin(prog_clock_pin),
		.prog_data_pin_in(prog_data_pin_in), .prog_data_pin_out(prog_data_pin_out),
		.prog_data_pin_oe(prog_data_pin_oe), .mem_addr(mem_addr), .mem_rd_req(mem_rd_req),
		.mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .mem_rd_data(mem_rd_data),
		.mem_start(mem_start), .mem_op(mem_op), .mem_erase_sel(mem_erase_sel),
		.mem_done(mem_done), .busy(busy), .mem_row_data(mem_row_data));
	nvm_host host (.prog_clock_pin(prog_clock_pin), .prog_data_pin_in(prog_data_pin_in),
		.prog_data_pin_out(prog_data_pin_out), .prog_data_pin_oe(prog_data_pin_oe));
	always @(posedge core_clk)
	begin
		if (mem_start)
		begin
			started <= 1'b1;
			cap_op <= mem_op;
			cap_sel <= mem_erase_sel;
		end
		if (mem_rd_req)
			rd_addr <= mem_addr;
		taken <= mem_rd_valid & mem_rd_ready;
	end
	// Memory offers a word until the buffer takes it
	always @(negedge core_clk)
	begin
		if (taken)
			mem_rd_valid = 1'b0;
		if (mem_rd_req)
			mem_rd_valid = 1'b1;
	end
	assign mem_rd_data = mem_rd_valid ? mem_w : ~mem_w;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset();
		@(negedge core_clk);
		rstn = 1'b0;
		repeat (5) @(negedge core_clk);
		rstn = 1'b1;
		prog_mode = 1'b1;
		chk({busy, prog_data_pin_oe, mem_addr}, 0);
		chk(&mem_row_data, 1);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(negedge core_clk);
		while (busy !== 1'b0 && n < 2000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(busy, 0);
	endtask
	task automatic load(input logic [7:0] cmd, input logic [21:0] v);
		host.frame(cmd, 1'b1, (cmd == CMD_LOAD_ADDR) ? {1'b0, v, 1'b0} : {7'h0, v[15:0], 1'b0}, rx);
	endtask
	initial
	begin
		#1_000_000;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			r = rows[i];
			@(negedge core_clk);
			code_protect_n = r.cp;
			mem_w = r.w;
			load(CMD_LOAD_ADDR, r.addr);
			started = 1'b0;
			host.frame(r.cmd, r.cmd[7:2] == 6'h3F, 24'h0, rx);
			if (r.cmd[7:2] == 6'h3F)
			begin
				chk(rx[16:1], r.e);
				chk(host.oe_falls, 23);
			end
			else
			begin
				if (r.cmd == CMD_BEGIN_EXT)
					host.frame(CMD_END_EXT, 1'b0, 24'h0, rx);
				wait_idle();
				chk({cap_sel & {4{cap_op == OP_ERASE_BULK}}, cap_op} & {9{started}},
					r.e);
			end
			chk(prog_data_pin_oe, 0);
			host.frame(CMD_READ_DATA, 1'b1, 24'h0, rx);
			chk(rd_addr, r.ea);
		end
		@(negedge core_clk);
		code_protect_n = 1'b1;
		started = 1'b0;
		load(CMD_LOAD_ADDR, 22'h4);
		load(CMD_LOAD_DATA_INC, 22'hBEEF);
		chk(mem_row_data[47:32], 16'hBEEF);
		load(CMD_LOAD_ADDR, 22'h44);
		load(CMD_LOAD_DATA, 22'hCAFE);
		chk(mem_row_data[47:32], 16'hCAFE);
		load(CMD_LOAD_ADDR, 22'h310007);
		load(CMD_LOAD_DATA, 22'h12);
		chk(mem_row_data[63:56], 8'h12);
		chk(started, 0);
		host.frame(CMD_BEGIN_INT, 1'b0, 24'h0, rx);
		wait_idle();
		chk(&mem_row_data, 1);
		load(CMD_LOAD_ADDR, 22'h40);
		@(negedge core_clk);
		prog_mode = 1'b0;
		repeat (2) @(negedge core_clk);
		prog_mode = 1'b1;
		chk(mem_addr, 0);
		host.half = 200;
		mem_w = 16'h2468;
		host.frame(CMD_READ_DATA, 1'b1, 24'h0, rx);
		chk({rd_addr, rx[16:1]}, {22'h0, 16'h2468});
		host.half = 80;
		do_reset();
		report_and_stop();
	end
endmodule
